//--- pkg/nim_map.vh
// constants for the nand id and address-map host controller
// Behaviour
// - The host sends each array address as four address cycles, least significant bits first.
// - On x8 the column goes as bits 0-7, then bits 8-11 on the low four lines with the upper four low.
// - On x8 cycles three and four carry the row, starting with page-in-block in bits 12-17.
// - On x8 the block address is bits 18-27 on the large part and 18-26 on the small, whose last line of cycle four is low.
// - On x16 the host sends bits 0-7, 8-10 on the low three lines, 11-18, then 19-26 (19-25 on the small part), all unused lines low.
// - The column bit just above the in-page offset picks main (0) or spare (1): bit 11 on x8, bit 10 on x16.
`ifndef NIM_MAP_VH
`define NIM_MAP_VH
`define NIM_REG_CTRL     12'h000
`define NIM_REG_ADDR     12'h004
`define NIM_REG_STAT     12'h008
`define NIM_REG_ID_LO    12'h00c
`define NIM_REG_ID_HI    12'h010
`define NIM_REG_DECODE   12'h014
`define NIM_CTRL_GO_ID   0
`define NIM_CTRL_GO_ADDR 1
`define NIM_CTRL_X16     2
`define NIM_CTRL_BIG     3
`define NIM_CTRL_CMD_LO  8
`define NIM_CMD_ID_READ  8'h90
`define NIM_ID_BYTES     5
`define NIM_ADDR_CYCLES  4
`define NIM_EXP_BYTE5    8'h22
`define NIM_T_WP_NS      25
`define NIM_T_WH_NS      10
`define NIM_T_RP_NS      17
`define NIM_T_REH_NS     8
`define NIM_T_WHR_NS     60
`define NIM_CLK_NS       5
`define NIM_CYC_UP(t)    (((t) + `NIM_CLK_NS - 1) / `NIM_CLK_NS)
`endif

//--- logic/nim_id_store.v
// small register store for the received id bytes
`timescale 1ns/1ps
module nim_id_store #(
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          rst_n,
  // write side
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [7:0]    wrData,
  // read side
  input  wire [AW-1:0] rdAddr,
  output reg  [7:0]    rdData
);
  reg [7:0] mem [0:DEPTH-1];
  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (!rst_n) begin
      rdData <= 8'h00;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule // nim_id_store

//--- logic/nim_host.v
// host controller: id read and four-cycle address issue over apb-programmed regs
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "nim_map.vh"
module nim_host #(
  parameter WP_CYC  = `NIM_CYC_UP(`NIM_T_WP_NS),
  parameter WH_CYC  = `NIM_CYC_UP(`NIM_T_WH_NS),
  parameter RP_CYC  = `NIM_CYC_UP(`NIM_T_RP_NS),
  parameter REH_CYC = `NIM_CYC_UP(`NIM_T_REH_NS),
  parameter WHR_CYC = `NIM_CYC_UP(`NIM_T_WHR_NS)
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // flash strobes
  output reg         chipEnable_n,
  output reg         cmdLatch,
  output reg         addrLatch,
  output reg         writeStrobe_n,
  output reg         read_strobe_n,
  // flash data lines
  input  wire [15:0] ioIn,
  output reg  [15:0] ioOut,
  output reg         ioOe
);
  localparam ST_IDLE = 3'd0, ST_WLOW = 3'd1, ST_WHIGH = 3'd2, ST_GAP = 3'd3;
  localparam ST_RLOW = 3'd4, ST_RHIGH = 3'd5, ST_DONE = 3'd6;
  // control and status
  reg        x16_q, big_q, busy_q, idDone_q, idOk_q, isId_q, upperBad_q;
  reg [27:0] addr_q;
  reg [2:0]  st_q;
  reg [2:0]  step_q;
  reg [7:0]  cnt_q;
  reg [7:0]  cmd_q;
  reg [39:0] idBytes_q;
  // three-stage input sync
  reg [15:0] io1_q, io2_q, io3_q, ioAcc_q;
  reg [2:0]  rdAddr_q;
  wire [7:0] storeData;
  wire       take = (st_q == ST_RLOW) && (cnt_q == 8'd0);
  wire [7:0] ioByte = ioAcc_q[7:0];
  wire       apbWr = psel && penable && pwrite && pready;
  // x8/x16 address cycle bytes, lsb first
  function [7:0] addrCycle;
    input [2:0]  n;
    input [27:0] a;
    input        w16;
    input        bigPart;
    begin
      addrCycle = 8'h00;
      if (!w16) begin
        case (n)
          3'd0: addrCycle = a[7:0];
          3'd1: addrCycle = {4'h0, a[11:8]};
          3'd2: addrCycle = a[19:12];
          3'd3: addrCycle = {bigPart & a[27], a[26:20]};
          default: addrCycle = 8'h00;
        endcase
      end else begin
        case (n)
          3'd0: addrCycle = a[7:0];
          3'd1: addrCycle = {5'h00, a[10:8]};
          3'd2: addrCycle = a[18:11];
          3'd3: addrCycle = {bigPart & a[26], a[25:19]};
          default: addrCycle = 8'h00;
        endcase
      end
    end
  endfunction
  nim_id_store #(.DEPTH(8), .AW(3)) idStore (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wrEn    (take && isId_q),
    .wrAddr  (step_q),
    .wrData  (ioByte),
    .rdAddr  (rdAddr_q),
    .rdData  (storeData)
  );
  always @(posedge clk_sys) begin
    io1_q <= ioIn;
    io2_q <= io1_q;
    io3_q <= io2_q;
    if (io2_q == io3_q) begin
      ioAcc_q <= io3_q;
    end
  end
  // apb register side
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      x16_q   <= 1'b0;
      big_q   <= 1'b0;
      addr_q  <= 28'h0000000;
      cmd_q   <= 8'h00;
      rdAddr_q <= 3'd0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= (paddr > `NIM_REG_DECODE) || (paddr[1:0] != 2'b00);
        case (paddr)
          `NIM_REG_CTRL:   prdata <= {16'h0000, cmd_q, 4'h0, big_q, x16_q, 2'b00};
          `NIM_REG_ADDR:   prdata <= {4'h0, addr_q};
          `NIM_REG_STAT:   prdata <= {29'h0, idOk_q, idDone_q, busy_q};
          `NIM_REG_ID_LO:  prdata <= idBytes_q[31:0];
          `NIM_REG_ID_HI:  prdata <= {24'h000000, idBytes_q[39:32]};
          `NIM_REG_DECODE: prdata <= {16'h0000, idBytes_q[39:32], idBytes_q[31:24]};
          default:         prdata <= 32'h00000000;
        endcase
      end
      if (apbWr && paddr == `NIM_REG_CTRL && !busy_q) begin
        x16_q <= pwdata[`NIM_CTRL_X16];
        big_q <= pwdata[`NIM_CTRL_BIG];
        cmd_q <= pwdata[`NIM_CTRL_CMD_LO+7:`NIM_CTRL_CMD_LO];
      end
      if (apbWr && paddr == `NIM_REG_ADDR && !busy_q) begin
        addr_q <= pwdata[27:0];
      end
      rdAddr_q <= step_q;
    end
  end
  wire goId   = apbWr && paddr == `NIM_REG_CTRL && pwdata[`NIM_CTRL_GO_ID];
  wire goAddr = apbWr && paddr == `NIM_REG_CTRL && pwdata[`NIM_CTRL_GO_ADDR];
  // pin sequencer: command, address cycles, then read strobes on an id read only
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q          <= ST_IDLE;
      step_q        <= 3'd0;
      cnt_q         <= 8'd0;
      busy_q        <= 1'b0;
      idDone_q      <= 1'b0;
      idOk_q        <= 1'b0;
      upperBad_q    <= 1'b0;
      isId_q        <= 1'b0;
      idBytes_q     <= 40'h0000000000;
      chipEnable_n  <= 1'b1;
      cmdLatch      <= 1'b0;
      addrLatch     <= 1'b0;
      writeStrobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      ioOut         <= 16'h0000;
      ioOe          <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if ((goId || goAddr) && !busy_q) begin
            busy_q       <= 1'b1;
            isId_q       <= goId;
            idDone_q     <= goId ? 1'b0 : idDone_q;
            idOk_q       <= goId ? 1'b0 : idOk_q;
            upperBad_q   <= goId ? 1'b0 : upperBad_q;
            chipEnable_n <= 1'b0;
            cmdLatch     <= 1'b1;
            ioOut        <= {8'h00, goId ? `NIM_CMD_ID_READ : pwdata[15:8]};
            ioOe         <= 1'b1;
            writeStrobe_n <= 1'b0;
            step_q       <= 3'd0;
            cnt_q        <= WP_CYC[7:0] - 8'd1;
            st_q         <= ST_WLOW;
          end
        end
        ST_WLOW: begin
          if (cnt_q != 8'd0) begin
            cnt_q <= cnt_q - 8'd1;
          end else begin
            writeStrobe_n <= 1'b1;
            cnt_q <= WH_CYC[7:0] - 8'd1;
            st_q  <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          if (cnt_q != 8'd0) begin
            cnt_q <= cnt_q - 8'd1;
          end else if (isId_q && addrLatch) begin
            addrLatch <= 1'b0;
            ioOe      <= 1'b0;
            cnt_q     <= WHR_CYC[7:0] - 8'd1;
            st_q      <= ST_GAP;
          end else if (!isId_q && addrLatch && step_q == `NIM_ADDR_CYCLES - 1) begin
            st_q <= ST_DONE;
          end else begin
            step_q    <= addrLatch ? step_q + 3'd1 : 3'd0;
            cmdLatch  <= 1'b0;
            addrLatch <= 1'b1;
            ioOut     <= {8'h00, isId_q ? 8'h00 :
                          addrCycle(addrLatch ? step_q + 3'd1 : 3'd0, addr_q, x16_q, big_q)};
            writeStrobe_n <= 1'b0;
            cnt_q <= WP_CYC[7:0] - 8'd1;
            st_q  <= ST_WLOW;
          end
        end
        ST_GAP: begin
          if (cnt_q != 8'd0) begin
            cnt_q <= cnt_q - 8'd1;
          end else begin
            step_q        <= 3'd0;
            read_strobe_n <= 1'b0;
            cnt_q <= RP_CYC[7:0] + 8'd2;
            st_q  <= ST_RLOW;
          end
        end
        ST_RLOW: begin
          if (cnt_q != 8'd0) begin
            cnt_q <= cnt_q - 8'd1;
          end else begin
            idBytes_q <= {ioByte, idBytes_q[39:8]};
            if (x16_q && ioAcc_q[15:8] != 8'h00) begin
              upperBad_q <= 1'b1;
            end
            read_strobe_n <= 1'b1;
            cnt_q <= REH_CYC[7:0] - 8'd1;
            st_q  <= ST_RHIGH;
          end
        end
        ST_RHIGH: begin
          if (cnt_q != 8'd0) begin
            cnt_q <= cnt_q - 8'd1;
          end else if (step_q == `NIM_ID_BYTES - 1) begin
            st_q   <= ST_DONE;
          end else begin
            step_q        <= step_q + 3'd1;
            read_strobe_n <= 1'b0;
            cnt_q <= RP_CYC[7:0] + 8'd2;
            st_q  <= ST_RLOW;
          end
        end
        ST_DONE: begin
          chipEnable_n <= 1'b1;
          cmdLatch     <= 1'b0;
          addrLatch    <= 1'b0;
          ioOe         <= 1'b0;
          busy_q       <= 1'b0;
          idDone_q     <= isId_q | idDone_q;
          if (isId_q) begin
            idOk_q <= (storeData == `NIM_EXP_BYTE5) && !upperBad_q;
          end
          st_q         <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // nim_host

//--- bench/nim_host_properties.sv
// assertions on the host controller pins
`timescale 1ns/1ps
module nim_host_props (
  // clock, reset and apb
  input wire        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  // flash pins
  input wire        chipEnable_n, cmdLatch, addrLatch, writeStrobe_n, read_strobe_n, ioOe,
  input wire [15:0] ioIn, ioOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  reg [2:0] nAddr_q;
  reg       ws_q;
  // address cycles inside one chip select
  always @(posedge clk_sys) begin
    ws_q <= writeStrobe_n;
    if (!rst_n || chipEnable_n) nAddr_q <= 3'h0;
    else if (addrLatch && ws_q && !writeStrobe_n) nAddr_q <= nAddr_q + 3'h1;
  end
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held");
  a_addr_count: assert property (nAddr_q <= 3'h4) else $error("address cycles");
  a_upper_low: assert property (addrLatch && !writeStrobe_n |-> ioOut[15:8] == 8'h00)
    else $error("upper byte driven");
  a_latch_excl: assert property (!(cmdLatch && addrLatch)) else $error("both latches");
  a_strobe_ce: assert property (!writeStrobe_n || !read_strobe_n |-> !chipEnable_n)
    else $error("strobe without select");
  a_read_float: assert property (!read_strobe_n |-> !ioOe) else $error("drive in read");
  a_drive_write: assert property (!writeStrobe_n |-> ioOe) else $error("write undriven");
  a_write_width: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n [*5])
    else $error("short write strobe");
  a_read_width: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*4])
    else $error("short read strobe");
endmodule // nim_host_props
bind nim_host nim_host_props i_props (.*);

//--- bench/nim_flash_model.sv
// flash device model answering id reads and logging address cycles
`timescale 1ns/1ps
module nim_flash_model (
  // strobes and bus mode
  input wire        chipEnable_n, cmdLatch, addrLatch, writeStrobe_n, read_strobe_n, w16,
  // data
  input wire [15:0] ioOut,
  input wire [39:0] idBytes,
  input wire        upperBad,
  output reg [15:0] ioIn
);
  reg [7:0]    cmd;
  integer      idx;
  logic [15:0] addrQ[$];
  initial begin
    ioIn = 16'hffff;
    cmd = 8'h00;
    idx = 0;
  end
  always @(posedge writeStrobe_n) if (!chipEnable_n) begin
    if (cmdLatch) begin
      cmd = ioOut[7:0];
      idx = 0;
      addrQ.delete();
    end else if (addrLatch) addrQ.push_back(ioOut);
  end
  always @(negedge read_strobe_n) if (!chipEnable_n && cmd == 8'h90 && idx < 5) begin
    ioIn = {w16 ? {7'h00, upperBad} : ~ioIn[15:8], idBytes[8*idx +: 8]};
    idx = idx + 1;
  end
  // released after the hold time: show the inverse
  always @(posedge read_strobe_n) ioIn <= #1 ~ioIn;
endmodule // nim_flash_model

//--- bench/tb.sv
// self-checking bench for the host controller
`timescale 1ns/1ps
`include "nim_map.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb;
  localparam [7:0] MAKER = 8'h5a; // arbitrary value
  reg        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, w16 = 0, err;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [39:0] idBytes = 40'h0;
  reg        upperBad = 0;
  reg [27:0] a;
  reg [9:0]  blk;
  reg [15:0] e[0:3];
  reg [7:0]  cmd;
  wire [31:0] prdata;
  wire [15:0] ioIn, ioOut;
  wire        pready, pslverr, chipEnable_n, cmdLatch, addrLatch, writeStrobe_n;
  wire        read_strobe_n, ioOe;
  integer     err_total = 0, n_tests = 0, cyc = 0, i, k;
  nim_host i_dut (.*);
  nim_flash_model i_flash (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report;
    end
  end
  task apb(input bit w, input [11:0] ad, input [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task run(input [31:0] c);
    apb(1, `NIM_REG_CTRL, c);
    k = 0;
    do begin apb(0, `NIM_REG_STAT, 0); k++; end while (rd[0] !== 1'b0 && k < 300);
    `CHK(rd[0], 1'b0)
  endtask
  initial begin
    void'($urandom(39));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    apb(0, `NIM_REG_STAT, 0);
    `CHK(rd[2:0], 3'h0)
    apb(0, 12'h018, 0);
    `CHK(err, 1'b1)
    // four variants, a wrong geometry byte, a driven upper byte; device codes arbitrary
    for (i = 0; i < 6; i++) begin
      w16 <= i[0];
      upperBad <= (i == 5);
      idBytes <= {(i < 4 || i == 5) ? `NIM_EXP_BYTE5 : 8'h12, 3'h0, 2'(i), 3'h0,
                  7'h0, i[1], 8'h40 + 8'(i), MAKER};
      run({29'h0, i[0], 2'b01});
      apb(0, `NIM_REG_ID_LO, 0);
      `CHK(rd, idBytes[31:0])
      apb(0, `NIM_REG_ID_HI, 0);
      `CHK(rd[7:0], idBytes[39:32])
      apb(0, `NIM_REG_DECODE, 0);
      `CHK(rd[15:0], idBytes[39:24])
      apb(0, `NIM_REG_STAT, 0);
      `CHK(rd[2:1], {i < 4, 1'b1})
      $display("id test %0d done", i);
    end
    for (i = 0; i < 8; i++) begin
      a = 28'($urandom);
      cmd = 8'h60 | 8'(i);
      w16 <= i[0];
      apb(1, `NIM_REG_ADDR, {4'h0, a});
      run({16'h0, cmd, 4'h0, i[1], i[0], 2'b10});
      e[0] = {8'h0, a[7:0]};
      if (i[0]) begin
        e[1] = {13'h0, a[10:8]};
        e[2] = {8'h0, a[18:11]};
        e[3] = {8'h0, i[1] & a[26], a[25:19]};
      end else begin
        e[1] = {12'h0, a[11:8]};
        e[2] = {8'h0, a[19:12]};
        e[3] = {8'h0, i[1] & a[27], a[26:20]};
      end
      `CHK(i_flash.cmd, cmd)
      `CHK(i_flash.addrQ.size(), 4)
      for (k = 0; k < 4; k++) `CHK(i_flash.addrQ[k], e[k])
      blk = i[0] ? {i[1] & a[26], a[25:17]} : {i[1] & a[27], a[26:18]};
      `CHK({i_flash.addrQ[3][7:0], i_flash.addrQ[2][7:6]}, blk)
      $display("address test %0d done", i);
    end
    // an address write while busy is refused
    apb(1, `NIM_REG_ADDR, 32'h00123456);
    apb(1, `NIM_REG_CTRL, 32'h00000001);
    apb(1, `NIM_REG_ADDR, 32'h0fedcba9);
    apb(0, `NIM_REG_STAT, 0);
    `CHK(rd[0], 1'b1)
    run(32'h00000000);
    apb(0, `NIM_REG_ADDR, 0);
    `CHK(rd, 32'h00123456)
    $display("busy test done");
    final_report;
  end
endmodule // tb
